// File: design/adcmc_regs.svh
// register offsets, field positions, reset values and timing counts of the mode and clock bank
// ****************************************************************************
// How it works
// R1: mode bit 13, reset zero, enables running check over register map.
// R2: mode bit 12, reset zero, enables check of incoming serial frame codes.
// R3: mode bit 11 picks check polynomial: zero CCITT-16 default, one ANSI-16.
// R4: mode bit 10 reads one after reset; host writes zero to clear it.
// R5: mode bits 9:8 word length; 00b 16 bits, 01b 24 bits at reset.
// R6: length 10b gives 32-bit words, result on top, zeros below.
// R7: length 11b gives 32-bit words, top byte copies the sign bit.
// R8: ready source 00b, reset value, follows last completing enabled channel.
// R9: ready source 01b drives the pin from OR of enabled channels.
// R10: ready source 10b and 11b follow first completing enabled channel, identically.
// R11: mode bit 1: idle pin high when zero, floating when one.
// R12: mode bit 0: zero holds pin low, one gives fixed low pulse.
// R13: clock bits 15:8 enable channels 0 to 7, all one at reset.
// R14: clock register sits at address 03h and resets to ff0eh.
// R15: clock bits 4:2 pick oversampling 128 shifted by code, default 011b.
// R16: disabled channels never influence the data-ready pin.
// R17: host writes zeros to reserved mode bits 7:5.
// ****************************************************************************
`ifndef ADCMC_REGS_SVH
`define ADCMC_REGS_SVH

`define ADCMC_ADDR_W        8
`define ADCMC_STATUS_ADDR   8'h01
`define ADCMC_MODE_ADDR     8'h02
`define ADCMC_CLOCK_ADDR    8'h03

`define ADCMC_MODE_RESET    16'h0510
`define ADCMC_CLOCK_RESET   16'hff0e
`define ADCMC_MODE_WMASK    16'h3f1f
`define ADCMC_CLOCK_WMASK   16'hffdf

`define ADCMC_MODE_REGCRC   13
`define ADCMC_MODE_RXCRC    12
`define ADCMC_MODE_CRCTYPE  11
`define ADCMC_MODE_RSTFLAG  10
`define ADCMC_MODE_WLEN_LO  8
`define ADCMC_MODE_TIMEOUT  4
`define ADCMC_MODE_RSRC_LO  2
`define ADCMC_MODE_FLOAT    1
`define ADCMC_MODE_PULSE    0
`define ADCMC_CLOCK_EN_LO   8
`define ADCMC_CLOCK_OSR_LO  2
`define ADCMC_STAT_MAPFAULT 13

`define ADCMC_POLY_CCITT    16'h1021
`define ADCMC_POLY_ANSI     16'h8005
`define ADCMC_CRC_SEED      16'hffff
`define ADCMC_OSR_BASE      15'h0080

`define ADCMC_CLK_PERIOD_NS 20
`define ADCMC_PULSE_NS      80
`define ADCMC_PULSE_CYC     ((`ADCMC_PULSE_NS + `ADCMC_CLK_PERIOD_NS - 1) / `ADCMC_CLK_PERIOD_NS)

`endif

// File: design/adcmc_pkg.sv
// types shared by the mode and clock configuration bank
package adcmc_pkg;
  typedef logic [1:0] adcmc_wlen_t;   // word length code
  typedef logic [1:0] adcmc_rsrc_t;   // ready source code
  typedef enum logic [1:0] {
    RDY_IDLE,
    RDY_PULSE,
    RDY_SPENT
  } adcmc_rdy_state_t;
endpackage

// File: design/adcmc_cfg_if.sv
// configuration fields passed from the register bank to its helpers
`timescale 1ns/1ps
`default_nettype none
interface adcmc_cfg_if;
  import adcmc_pkg::*;
  adcmc_wlen_t word_length_select;
  adcmc_rsrc_t ready_source_select;
  logic        ready_idle_float;
  logic        ready_signal_format;
  logic [7:0]  chan_enable;
  modport src (output word_length_select, ready_source_select, ready_idle_float,
               ready_signal_format, chan_enable);
  modport fmt (input word_length_select);
  modport rdy (input ready_source_select, ready_idle_float, ready_signal_format, chan_enable);
endinterface
`default_nettype wire

// File: design/adcmc_word_fmt.sv
// output word shaping: 16, 24 or 32 bits from a 24-bit result
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_regs.svh"
module adcmc_word_fmt
  import adcmc_pkg::*;
(
  input  wire logic        clk,        // system clock
  input  wire logic        rstn,       // async reset, active low
  adcmc_cfg_if.fmt         cfg,        // word length setting
  input  wire logic        smp_valid,  // result strobe
  input  wire logic [23:0] smp_data,   // 24-bit result
  output logic             word_valid, // shaped word strobe
  output logic [31:0]      word_data   // shaped word, low-justified except length 10b, which puts the result on top
);
  logic        next_word_valid;
  logic [31:0] next_word_data;

  // ***************************************************************
  // shaping
  // ***************************************************************
  function automatic logic [31:0] shape(input adcmc_wlen_t len, input logic [23:0] d);
    case (len)
      2'b00:   shape = {16'h0000, d[23:8]};         // truncation keeps msbs
      2'b01:   shape = {8'h00, d};
      2'b10:   shape = {d, 8'h00};                  // R6
      2'b11:   shape = {{8{d[23]}}, d};             // R7
      default: shape = {8'h00, d};
    endcase
  endfunction

  // compute next word
  always_comb begin
    next_word_valid = smp_valid;
    next_word_data  = smp_valid ? shape(cfg.word_length_select, smp_data) : word_data; // R5
  end

  // register outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_valid <= 1'b0;
      word_data  <= 32'h0000_0000;
    end else begin
      word_valid <= next_word_valid;
      word_data  <= next_word_data;
    end
  end
endmodule
`default_nettype wire

// File: design/adcmc_ready_gen.sv
// data-ready pin generation from per-channel completions
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_regs.svh"
module adcmc_ready_gen
  import adcmc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `ADCMC_PULSE_CYC
)(
  input  wire logic       clk,        // system clock
  input  wire logic       rstn,       // async reset, active low
  adcmc_cfg_if.rdy        cfg,        // ready settings
  input  wire logic [7:0] chan_done,  // per-channel completion pulses
  input  wire logic       data_read,  // host consumed the frame
  output logic [7:0]      pending,    // per-channel new data flags
  output logic            ready_o,    // pin level
  output logic            ready_oe    // pin drive enable
);
  adcmc_rdy_state_t state, next_state;
  logic [7:0]  next_pending;
  logic [7:0]  cnt, next_cnt;
  logic        avail, next_ready_o, next_ready_oe;
  logic [7:0]  act;

  // ***************************************************************
  // availability
  // ***************************************************************
  // a completion in the clearing cycle survives the clear
  always_comb begin
    next_pending = (data_read ? 8'h00 : pending) | (chan_done & cfg.chan_enable);
    act          = pending & cfg.chan_enable;                          // R16
    case (cfg.ready_source_select)
      2'b00:   avail = (cfg.chan_enable != 8'h00) && (act == cfg.chan_enable); // R8
      2'b01:   avail = |act;                                           // R9
      default: avail = |act;                                           // R10
    endcase
  end

  // pulse sequencer and pin drive
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_ready_o  = 1'b1;
    next_ready_oe = !cfg.ready_idle_float;                             // R11
    case (state)
      RDY_IDLE: begin
        if (avail && cfg.ready_signal_format) begin
          next_state = RDY_PULSE;
          next_cnt   = 8'(PULSE_CYC - 1);
        end
      end
      RDY_PULSE: begin
        if (cnt == 8'h00) begin
          next_state = RDY_SPENT;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      RDY_SPENT: begin
        if (!avail) begin
          next_state = RDY_IDLE;
        end
      end
      default: next_state = RDY_IDLE;
    endcase
    // level format: low for as long as data wait; pulse format: fixed low pulse
    if ((avail && !cfg.ready_signal_format) || next_state == RDY_PULSE) begin // R12
      next_ready_o  = 1'b0;
      next_ready_oe = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state    <= RDY_IDLE;
      cnt      <= 8'h00;
      pending  <= 8'h00;
      ready_o  <= 1'b1;
      ready_oe <= 1'b1;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      pending  <= next_pending;
      ready_o  <= next_ready_o;
      ready_oe <= next_ready_oe;
    end
  end
endmodule
`default_nettype wire

// File: design/adcmc_top.sv
// mode and clock configuration bank with register-map check, word shaping and ready pin
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_regs.svh"
module adcmc_top
  import adcmc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `ADCMC_PULSE_CYC
)(
  input  wire logic                     clk,              // system clock, 50 MHz
  input  wire logic                     rstn,             // async reset, active low
  input  wire logic [`ADCMC_ADDR_W-1:0] reg_addr,         // register address
  input  wire logic [15:0]              reg_wdata,        // write data
  input  wire logic                     reg_we,           // write strobe
  input  wire logic                     reg_re,           // read strobe
  output logic      [15:0]              reg_rdata,        // read data, cycle after strobe
  input  wire logic [7:0]               chan_done,        // per-channel completion pulses
  input  wire logic                     data_read,        // host consumed a frame
  input  wire logic                     smp_valid,        // result strobe
  input  wire logic [23:0]              smp_data,         // 24-bit result
  output logic                          word_valid,       // shaped word strobe
  output logic      [31:0]              word_data,        // shaped word
  output logic                          data_ready_o,     // ready pin level
  output logic                          data_ready_oe,    // ready pin drive enable
  output logic                          reg_crc_enable,   // register map check on
  output logic                          rx_crc_enable,    // serial frame check on
  output logic                          crc_poly_ansi,    // polynomial select
  output logic                          spi_timeout_enable, // serial timeout on
  output logic      [15:0]              reg_map_crc,      // running map check value
  output logic      [2:0]               oversampling_ratio_select, // ratio code
  output logic      [14:0]              osr_ratio         // ratio value
);
  logic [15:0] operating_mode, next_operating_mode;
  logic [15:0] clock_and_channel_enable, next_clock_and_channel_enable;
  logic [15:0] next_reg_rdata;
  logic [15:0] next_reg_map_crc;
  logic [15:0] map_ref, next_map_ref;
  logic        map_fault, next_map_fault;
  logic        map_sync, next_map_sync;
  logic [7:0]  pending;
  logic [15:0] status_word;
  logic        wr_mode, wr_clock, rd_status;

  adcmc_cfg_if cfg ();

  // ***************************************************************
  // helpers
  // ***************************************************************
  // bitwise crc16 over one 32-bit block, msb first
  function automatic logic [15:0] crc16(input logic [15:0] seed, input logic [15:0] poly,
                                        input logic [31:0] data);
    logic [15:0] c;
    c = seed;
    for (int i = 31; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ poly;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc16 = c;
  endfunction

  // write-enable decode shared by both registers
  function automatic logic hit(input logic [`ADCMC_ADDR_W-1:0] a,
                               input logic [`ADCMC_ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  assign wr_mode   = reg_we && hit(reg_addr, `ADCMC_MODE_ADDR);
  assign wr_clock  = reg_we && hit(reg_addr, `ADCMC_CLOCK_ADDR);   // R14
  assign rd_status = reg_re && hit(reg_addr, `ADCMC_STATUS_ADDR);

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  // reserved bits are masked on write so they always read zero
  always_comb begin
    next_operating_mode           = operating_mode;
    next_clock_and_channel_enable = clock_and_channel_enable;
    if (wr_mode) begin
      next_operating_mode = reg_wdata & `ADCMC_MODE_WMASK;          // R17
      // the reset flag can only be cleared by software, never set
      next_operating_mode[`ADCMC_MODE_RSTFLAG] =
        operating_mode[`ADCMC_MODE_RSTFLAG] & reg_wdata[`ADCMC_MODE_RSTFLAG]; // R4
    end
    if (wr_clock) begin
      next_clock_and_channel_enable = reg_wdata & `ADCMC_CLOCK_WMASK; // R13
    end
  end

  // reset values hold the flag, the 24-bit length and all channels on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      operating_mode           <= `ADCMC_MODE_RESET;               // R1 R2 R3 R4 R5
      clock_and_channel_enable <= `ADCMC_CLOCK_RESET;              // R13 R14 R15
    end else begin
      operating_mode           <= next_operating_mode;
      clock_and_channel_enable <= next_clock_and_channel_enable;
    end
  end

  // ***************************************************************
  // field outputs
  // ***************************************************************
  assign reg_crc_enable     = operating_mode[`ADCMC_MODE_REGCRC];   // R1
  assign rx_crc_enable      = operating_mode[`ADCMC_MODE_RXCRC];    // R2
  assign crc_poly_ansi      = operating_mode[`ADCMC_MODE_CRCTYPE];  // R3
  assign spi_timeout_enable = operating_mode[`ADCMC_MODE_TIMEOUT];
  assign oversampling_ratio_select = clock_and_channel_enable[`ADCMC_CLOCK_OSR_LO +: 3];
  assign osr_ratio = `ADCMC_OSR_BASE << oversampling_ratio_select;   // R15

  // configuration handed to the helpers
  assign cfg.word_length_select  = operating_mode[`ADCMC_MODE_WLEN_LO +: 2];  // R5
  assign cfg.ready_source_select = operating_mode[`ADCMC_MODE_RSRC_LO +: 2];
  assign cfg.ready_idle_float    = operating_mode[`ADCMC_MODE_FLOAT];
  assign cfg.ready_signal_format = operating_mode[`ADCMC_MODE_PULSE];
  assign cfg.chan_enable         = clock_and_channel_enable[`ADCMC_CLOCK_EN_LO +: 8]; // R13

  // ***************************************************************
  // register map check
  // ***************************************************************
  // the check runs over both registers each cycle; a host write resyncs
  // the reference so only an unexpected change counts as a fault
  always_comb begin
    next_reg_map_crc = reg_map_crc;
    next_map_ref     = map_ref;
    next_map_sync    = 1'b0;
    next_map_fault   = rd_status ? 1'b0 : map_fault;
    if (reg_crc_enable) begin                                       // R1
      next_reg_map_crc = crc16(`ADCMC_CRC_SEED,
                               crc_poly_ansi ? `ADCMC_POLY_ANSI : `ADCMC_POLY_CCITT, // R3
                               {operating_mode, clock_and_channel_enable});
      next_map_sync = !reg_we;
      if (!map_sync) begin
        next_map_ref = next_reg_map_crc;
      end else if (next_reg_map_crc != map_ref) begin
        next_map_fault = 1'b1;                                      // set beats read clear
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_map_crc <= `ADCMC_CRC_SEED;
      map_ref     <= `ADCMC_CRC_SEED;
      map_fault   <= 1'b0;
      map_sync    <= 1'b0;
    end else begin
      reg_map_crc <= next_reg_map_crc;
      map_ref     <= next_map_ref;
      map_fault   <= next_map_fault;
      map_sync    <= next_map_sync;
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  // status mirrors the reset flag and live data flags
  always_comb begin
    status_word = 16'h0000;
    status_word[`ADCMC_STAT_MAPFAULT]          = map_fault;
    status_word[`ADCMC_MODE_CRCTYPE]           = crc_poly_ansi;
    status_word[`ADCMC_MODE_RSTFLAG]           = operating_mode[`ADCMC_MODE_RSTFLAG]; // R4
    status_word[`ADCMC_MODE_WLEN_LO +: 2]      = cfg.word_length_select;
    status_word[7:0]                           = pending;
  end

  // unmapped addresses read as zero; data stands one cycle only
  always_comb begin
    next_reg_rdata = 16'h0000;
    if (reg_re) begin
      case (reg_addr)
        `ADCMC_STATUS_ADDR: next_reg_rdata = status_word;
        `ADCMC_MODE_ADDR:   next_reg_rdata = operating_mode;
        `ADCMC_CLOCK_ADDR:  next_reg_rdata = clock_and_channel_enable; // R14
        default:            next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ***************************************************************
  // helpers instances
  // ***************************************************************
  adcmc_word_fmt u_fmt (
    .clk        (clk),
    .rstn       (rstn),
    .cfg        (cfg),
    .smp_valid  (smp_valid),
    .smp_data   (smp_data),
    .word_valid (word_valid),
    .word_data  (word_data)
  );

  adcmc_ready_gen #(
    .PULSE_CYC (PULSE_CYC)
  ) u_rdy (
    .clk       (clk),
    .rstn      (rstn),
    .cfg       (cfg),
    .chan_done (chan_done),
    .data_read (data_read),
    .pending   (pending),
    .ready_o   (data_ready_o),
    .ready_oe  (data_ready_oe)
  );
endmodule
`default_nettype wire

// File: bench/adcmc_top_checker.sv
// port assertions for the mode and clock configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_regs.svh"
module adcmc_top_checker
  import adcmc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = 4
)(
  input wire logic        clk,                       // clock
  input wire logic        rstn,                      // reset, active low
  input wire logic [7:0]  reg_addr,                  // address
  input wire logic [15:0] reg_wdata,                 // write data
  input wire logic        reg_we,                    // write strobe
  input wire logic        reg_re,                    // read strobe
  input wire logic [15:0] reg_rdata,                 // read data
  input wire logic        smp_valid,                 // result strobe
  input wire logic [23:0] smp_data,                  // result
  input wire logic        word_valid,                // word strobe
  input wire logic [31:0] word_data,                 // shaped word
  input wire logic        data_ready_o,              // pin level
  input wire logic        data_ready_oe,             // pin enable
  input wire logic        reg_crc_enable,            // map check on
  input wire logic        rx_crc_enable,             // frame check on
  input wire logic        crc_poly_ansi,             // polynomial
  input wire logic [2:0]  oversampling_ratio_select, // ratio code
  input wire logic [14:0] osr_ratio                  // ratio value
);
  logic [15:0] sm;     // mode shadow
  logic [15:0] sc;     // clock shadow
  logic [7:0]  lo_run; // low run length in pulse mode
  // ****************************************
  // shadows, so checks never trust a readback
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sm <= `ADCMC_MODE_RESET;
      sc <= `ADCMC_CLOCK_RESET;
      lo_run <= 8'h00;
    end else begin
      // flag bit can only be cleared, never set, by the host
      if (reg_we && reg_addr == `ADCMC_MODE_ADDR) begin
        sm <= (reg_wdata & `ADCMC_MODE_WMASK & 16'hfbff) | (sm & reg_wdata & 16'h0400);
      end
      if (reg_we && reg_addr == `ADCMC_CLOCK_ADDR) begin
        sc <= reg_wdata & `ADCMC_CLOCK_WMASK;
      end
      lo_run <= (sm[0] && !data_ready_o && data_ready_oe) ? lo_run + 8'h01 : 8'h00;
    end
  end
  function automatic logic [31:0] shp(input logic [1:0] c, input logic [23:0] d);
    case (c)
      2'b00:   return {16'h0000, d[23:8]};
      2'b01:   return {8'h00, d};
      2'b10:   return {d, 8'h00};
      default: return {{8{d[23]}}, d};
    endcase
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_regcrc; reg_crc_enable == sm[13]; endproperty
  a_regcrc: assert property (p_regcrc) else $error("map check enable wrong");
  property p_rxcrc; rx_crc_enable == sm[12]; endproperty
  a_rxcrc: assert property (p_rxcrc) else $error("frame check enable wrong");
  property p_poly; crc_poly_ansi == sm[11]; endproperty
  a_poly: assert property (p_poly) else $error("polynomial select wrong");
  property p_mode_rd; reg_re && reg_addr == `ADCMC_MODE_ADDR |=> reg_rdata == $past(sm); endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
  property p_clk_rd; reg_re && reg_addr == `ADCMC_CLOCK_ADDR |=> reg_rdata == $past(sc); endproperty
  a_clk_rd: assert property (p_clk_rd) else $error("clock readback wrong");
  property p_word;
    smp_valid |=> word_valid && word_data == shp($past(sm[9:8]), $past(smp_data));
  endproperty
  a_word: assert property (p_word) else $error("shaped word wrong");
  property p_osr;
    oversampling_ratio_select == sc[4:2] && osr_ratio == (15'h0080 << sc[4:2]);
  endproperty
  a_osr: assert property (p_osr) else $error("ratio wrong");
  property p_idle_hi; !sm[1] && !$past(sm[1]) |-> data_ready_oe; endproperty
  a_idle_hi: assert property (p_idle_hi) else $error("pin not driven");
  property p_float; sm[1] && $past(sm[1]) && data_ready_oe |-> !data_ready_o; endproperty
  a_float: assert property (p_float) else $error("pin driven high while floating");
  property p_pulse; lo_run <= PULSE_CYC; endproperty
  a_pulse: assert property (p_pulse) else $error("ready pulse too long");
  c_sext: cover property (smp_valid && sm[9:8] == 2'b11);
  c_pulse: cover property (sm[0] && !data_ready_o);
  c_clear: cover property (reg_we && reg_addr == `ADCMC_MODE_ADDR && !reg_wdata[10]);
endmodule
bind adcmc_top adcmc_top_checker #(.PULSE_CYC(PULSE_CYC)) i_adcmc_top_checker (.*);
`default_nettype wire

// File: bench/adcmc_host_model.sv
// serial host controller model: register reads and writes
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_regs.svh"
module adcmc_host_model (
  input  wire logic        clk,       // clock
  input  wire logic [15:0] reg_rdata, // read data
  output var  logic [7:0]  reg_addr,  // address
  output var  logic [15:0] reg_wdata, // write data
  output var  logic        reg_we,    // write strobe
  output var  logic        reg_re     // read strobe
);
  initial {reg_addr, reg_wdata, reg_we, reg_re} = 26'h0;
  // one-cycle write; reserved mode bits 7:5 always go out as zero
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= (a == `ADCMC_MODE_ADDR) ? (d & 16'hff1f) : d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just then
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // acknowledge a reset by writing the flag bit as zero
  task automatic clear_reset_flag(input logic [15:0] m);
    wr(`ADCMC_MODE_ADDR, m & 16'hfbff);
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the mode and clock configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_regs.svh"
module tb_top;
  import adcmc_pkg::*;
  localparam int unsigned PC = 3; // short pulse keeps the run brief
  localparam logic [31:0] EXPW [4] = '{32'h000089ab, 32'h0089abcd, 32'h89abcd00, 32'hff89abcd};
  logic clk, rstn, reg_we, reg_re, data_read, smp_valid, word_valid;
  logic data_ready_o, data_ready_oe, reg_crc_enable, rx_crc_enable, crc_poly_ansi;
  logic spi_timeout_enable;
  logic [7:0]  reg_addr, chan_done;
  logic [15:0] reg_wdata, reg_rdata, rv, reg_map_crc;
  logic [23:0] smp_data;
  logic [31:0] word_data;
  logic [2:0]  oversampling_ratio_select;
  logic [14:0] osr_ratio;
  int n_fail, comparisons, k, n;
  adcmc_top #(.PULSE_CYC(PC)) i_adcmc_top (.*);
  adcmc_host_model i_adcmc_host_model (.*);
  always #10 clk = ~clk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    i_adcmc_host_model.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic mode(input logic [15:0] m);
    i_adcmc_host_model.wr(`ADCMC_MODE_ADDR, m);
  endtask
  // one-cycle strobes on the completion and consume inputs
  task automatic pend(input logic [7:0] m);
    @(posedge clk);
    chan_done <= m;
    @(posedge clk);
    chan_done <= 8'h00;
  endtask
  task automatic drain();
    @(posedge clk);
    data_read <= 1'b1;
    @(posedge clk);
    data_read <= 1'b0;
  endtask
  // bounded wait on the pin; a miss ends the run
  task automatic wait_pin(input logic e);
    #1;
    n = 0;
    while (data_ready_o !== e && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(data_ready_o, e);
    if (data_ready_o !== e) end_of_test();
  endtask
  task automatic hold(input logic e);
    repeat (4) @(posedge clk);
    #1;
    chk(data_ready_o, e);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {clk, rstn, chan_done, data_read, smp_valid, smp_data} = 36'h0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rchk(`ADCMC_MODE_ADDR, 16'h0510);
    rchk(`ADCMC_CLOCK_ADDR, 16'hff0e);
    rchk(8'h7f, 16'h0000);
    chk({spi_timeout_enable, osr_ratio, reg_map_crc}, {1'b1, 15'h0400, 16'hffff});
    i_adcmc_host_model.rd(`ADCMC_STATUS_ADDR, rv);
    chk(rv[11:8], 4'h5);
    // every mode bit set, then the flag cleared and not set again
    mode(16'hffff);
    rchk(`ADCMC_MODE_ADDR, 16'h3f1f);
    chk({reg_crc_enable, rx_crc_enable, crc_poly_ansi}, 3'b111);
    i_adcmc_host_model.clear_reset_flag(16'h0000);
    rchk(`ADCMC_MODE_ADDR, 16'h0000);
    chk({reg_crc_enable, rx_crc_enable, crc_poly_ansi}, 3'b000);
    i_adcmc_host_model.rd(`ADCMC_STATUS_ADDR, rv);
    chk(rv[10], 1'b0);
    mode(16'hffff);
    rchk(`ADCMC_MODE_ADDR, 16'h3b1f);
    // every ratio code
    for (k = 0; k < 8; k++) begin
      i_adcmc_host_model.wr(`ADCMC_CLOCK_ADDR, 16'hff02 | 16'(k << 2));
      #1;
      chk(osr_ratio, 32'h80 << k);
    end
    rchk(`ADCMC_STATUS_ADDR, 16'h0b00);
    i_adcmc_host_model.wr(`ADCMC_CLOCK_ADDR, 16'hffff);
    rchk(`ADCMC_CLOCK_ADDR, 16'hffdf);
    i_adcmc_host_model.wr(`ADCMC_CLOCK_ADDR, 16'hff0e);
    // every word length with a negative result
    for (k = 0; k < 4; k++) begin
      mode(16'(k << 8));
      @(posedge clk);
      smp_valid <= 1'b1;
      smp_data <= 24'h89abcd;
      @(posedge clk);
      smp_valid <= 1'b0;
      #1;
      chk({word_valid, word_data}, {1'b1, EXPW[k]});
    end
    // any enabled channel
    mode(16'h0004);
    pend(8'h01);
    wait_pin(1'b0);
    drain();
    wait_pin(1'b1);
    // last enabled channel
    mode(16'h0000);
    pend(8'h01);
    hold(1'b1);
    pend(8'hfe);
    wait_pin(1'b0);
    drain();
    wait_pin(1'b1);
    // first enabled channel, both codes
    for (k = 2; k < 4; k++) begin
      mode(16'(k << 2));
      pend(8'h08);
      wait_pin(1'b0);
      drain();
      wait_pin(1'b1);
    end
    // channel 2 off takes no part in either source
    i_adcmc_host_model.wr(`ADCMC_CLOCK_ADDR, 16'hfb0e);
    mode(16'h0004);
    pend(8'h04);
    hold(1'b1);
    mode(16'h0000);
    pend(8'hfb);
    wait_pin(1'b0);
    drain();
    wait_pin(1'b1);
    i_adcmc_host_model.wr(`ADCMC_CLOCK_ADDR, 16'hff0e);
    // floating idle
    mode(16'h0006);
    hold(1'b1);
    chk(data_ready_oe, 1'b0);
    pend(8'h01);
    wait_pin(1'b0);
    chk(data_ready_oe, 1'b1);
    drain();
    hold(1'b1);
    chk(data_ready_oe, 1'b0);
    // fixed low pulse, then idle while data still wait
    mode(16'h0005);
    pend(8'h01);
    wait_pin(1'b0);
    wait_pin(1'b1);
    chk(n, PC);
    hold(1'b1);
    drain();
    end_of_test();
  end
endmodule
`default_nettype wire
